// ---- verilog/fwiu_top.sv ----
// Purpose: Shared 96-byte FIFO, water-level events, status and event flags
// Assumes: Serial-port pins sampled directly on ref_clk, which far outruns SCLK
// Notes:   Flag registers clear at the end of their serial read byte
//
// Behaviour
// - Any event sets its flag in the main or an auxiliary flag register; an unmasked one raises irq.
// - Main flags: six direct sources plus two pointers to auxiliary flag registers.
// - Reading a flag register clears it, except the two pointer bits.
// - A pointer bit stays set until its auxiliary register has been read.
// - Irq falls only after every unmasked pending flag has been read.
// - A masked source still sets its flag but does not raise irq.
// - Provide one 96-byte FIFO shared by transmit and receive data.
// - Transmit feeds FIFO bytes to framer; receive stores incoming bytes in FIFO.
// - Transmit water event when count falls from level+1 to level, frame incomplete.
// - Receive water event when count rises from level-1 to level.
// - Short transmit load, frame incomplete: water event when count drops below 4.
// - No water events while the serial port is in FIFO load or read.
// - Two selectable water levels each for receive and transmit via config bits.
// - Reception start clears the FIFO and both FIFO status registers.
// - Status reports unread FIFO byte count, readable live during transfers.
// - Second status holds incomplete flag, 3-bit valid count, parity flag; read clears.
// - Overflow flag on any write to a full FIFO, receive or host load.
// - Underflow flag on any read from empty FIFO, host or transmitter.
// - FIFO access is mode 10 with trailer all zero load, all one read.
// - A FIFO byte aborted mid-shift stays unread and comes first next time.
`timescale 1ns/1ns
`default_nettype none
`include "fwiu_defs.svh"
module fwiu_top (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 ss_n,
  input  wire logic                 sclk,
  input  wire logic                 mosi,
  output var  logic                 miso,
  output var  logic                 miso_oe,
  output var  logic                 irq,
  input  wire logic [4:0]           main_evt,
  input  wire logic [7:0]           tp_evt,
  input  wire logic [7:0]           ew_evt,
  input  wire logic                 rx_active,
  input  wire logic                 rx_start,
  input  wire logic                 rx_byte_valid,
  input  wire fwiu_pkg::fwiu_byte_t rx_byte,
  input  wire logic                 rx_last_set,
  input  wire logic                 rx_last_incomplete,
  input  wire logic [2:0]           rx_last_bits,
  input  wire logic                 rx_last_parity,
  input  wire logic                 tx_active,
  input  wire logic                 tx_start,
  input  wire logic                 tx_frame_loaded,
  input  wire logic                 tx_ready,
  output wire fwiu_pkg::fwiu_byte_t tx_data,
  output wire logic                 tx_valid
);
  import fwiu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Serial port front end

  fwiu_spi_state_t state_q;
  fwiu_spi_state_t state_d;
  logic            sclk_prev_q;
  logic [2:0]      bit_cnt_q;
  logic [6:0]      sh_in_q;
  logic [6:0]      sh_out_q;
  logic [5:0]      addr_q;
  logic            fread_empty_q;

  wire        sclk_fall = ~ss_n & sclk_prev_q & ~sclk;
  wire        sclk_rise = ~ss_n & ~sclk_prev_q & sclk;
  wire [7:0]  byte_in   = {sh_in_q, mosi};
  wire        byte_done = sclk_fall & (bit_cnt_q == 3'h7);
  wire [1:0]  cmd_mode  = byte_in[7:6];
  wire [5:0]  cmd_trail = byte_in[5:0];
  wire        in_cmd    = (state_q == SP_CMD);
  wire        in_write  = (state_q == SP_WRITE);
  wire        in_read   = (state_q == SP_READ);
  wire        in_load   = (state_q == SP_LOAD);
  wire        in_fread  = (state_q == SP_FREAD);
  wire        reg_done  = byte_done & in_read;
  wire        wr_reg    = byte_done & in_write;
  wire        ld_push   = byte_done & in_load;
  wire        out_load  = sclk_rise & (bit_cnt_q == 3'h0) & (in_read | in_fread);

  always_comb begin
    state_d = state_q;
    if (byte_done && in_cmd) begin
      unique case (cmd_mode)
        `FWIU_MODE_WRITE:  state_d = SP_WRITE;
        `FWIU_MODE_READ:   state_d = SP_READ;
        `FWIU_MODE_DIRECT: state_d = SP_CMD; // Immediate commands may chain
        `FWIU_MODE_FIFO: begin
          if (cmd_trail == `FWIU_TRAILER_LOAD) begin
            state_d = SP_LOAD;
          end else if (cmd_trail == `FWIU_TRAILER_FREAD) begin
            state_d = SP_FREAD;
          end else begin
            state_d = SP_IGNORE;
          end
        end
      endcase
    end
  end

  // Select high holds the port in reset; FIFO mode lasts until then
  always_ff @(posedge ref_clk) begin
    if (reset || ss_n) begin
      state_q   <= SP_CMD;
      bit_cnt_q <= 3'h0;
      sh_in_q   <= 7'h00;
    end else begin
      state_q <= state_d;
      if (sclk_fall) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        sh_in_q   <= byte_in[6:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sclk_prev_q <= 1'b0;
      addr_q      <= 6'h00;
    end else begin
      sclk_prev_q <= sclk;
      if (byte_done && in_cmd) begin
        addr_q <= cmd_trail;
      end else if (byte_done && (in_read || in_write)) begin
        addr_q <= addr_q + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte store, pointers and occupancy

  logic [6:0] wr_ptr_q;
  logic [6:0] rd_ptr_q;
  logic [6:0] count_q;
  logic       rd_stable_q;
  fwiu_byte_t mem_rdata;
  wire        buf_in_ready;

  function automatic logic [6:0] ptr_next(input logic [6:0] p);
    ptr_next = (p == `FWIU_PTR_LAST) ? 7'h00 : p + 7'h01;
  endfunction

  wire        fifo_empty = (count_q == 7'h00);
  wire        fifo_full  = (count_q == `FWIU_FIFO_DEPTH);
  wire        fifo_clr   = rx_start;
  wire        wr_req     = rx_byte_valid | ld_push;
  wire        push_ok    = wr_req & ~fifo_full;
  wire        ovf_evt    = wr_req & fifo_full;
  fwiu_byte_t wr_data;
  assign wr_data = rx_byte_valid ? rx_byte : byte_in;

  // Host pops only once the whole byte has left, so an aborted byte stays
  wire host_pop  = byte_done & in_fread & ~fread_empty_q;
  wire host_udf  = byte_done & in_fread & fread_empty_q;
  // Read data lags the pointer one cycle, so fetch only when it has settled
  wire tx_pop    = tx_active & ~in_fread & buf_in_ready & rd_stable_q & ~fifo_empty;
  wire pop       = host_pop | tx_pop;
  wire tx_udf    = tx_active & tx_ready & ~tx_valid & fifo_empty & ~tx_frame_loaded;

  logic [6:0] count_d;
  assign count_d = fifo_clr ? 7'h00
                 : count_q + {6'h00, push_ok} - {6'h00, pop};

  always_ff @(posedge ref_clk) begin
    if (reset || fifo_clr) begin
      wr_ptr_q <= 7'h00;
      rd_ptr_q <= 7'h00;
    end else begin
      if (push_ok) begin
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_q     <= 7'h00;
      rd_stable_q <= 1'b0;
    end else begin
      count_q     <= count_d;
      rd_stable_q <= ~pop & ~push_ok & ~fifo_clr;
    end
  end

  fwiu_mem u_mem (
    .ref_clk (ref_clk),
    .we      (push_ok),
    .waddr   (wr_ptr_q),
    .wdata   (wr_data),
    .raddr   (rd_ptr_q),
    .rdata_q (mem_rdata)
  );

  fwiu_buf #(
    .WIDTH (8),
    .DEPTH (`FWIU_BUF_DEPTH)
  ) u_buf (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .flush     (tx_start),
    .in_valid  (tx_pop),
    .in_ready  (buf_in_ready),
    .in_data   (mem_rdata),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Water-level detection

  logic [7:0] cfg_q;
  logic [6:0] load_total_q;

  wire [6:0] wl_rx = cfg_q[`FWIU_CFG_WL_RX] ? `FWIU_WL_RX1 : `FWIU_WL_RX0;
  wire [6:0] wl_tx = cfg_q[`FWIU_CFG_WL_TX] ? `FWIU_WL_TX1 : `FWIU_WL_TX0;
  wire tx_cross = (count_q == wl_tx + 7'h01) & (count_d == wl_tx);
  wire tx_low   = (load_total_q < wl_tx) & (count_q == `FWIU_TX_LOW)
                & (count_d == `FWIU_TX_LOW - 7'h01);
  wire rx_cross = (count_q == wl_rx - 7'h01) & (count_d == wl_rx);
  wire spi_fifo = in_load | in_fread;
  wire wl_evt   = ~spi_fifo
                & ((tx_active & ~tx_frame_loaded & (tx_cross | tx_low))
                 | (rx_active & rx_cross));

  // Counts host loads per frame to spot a load shorter than the level
  always_ff @(posedge ref_clk) begin
    if (reset || tx_start) begin
      load_total_q <= 7'h00;
    end else if (ld_push && load_total_q != 7'h7f) begin
      load_total_q <= load_total_q + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags, masks and interrupt

  logic [5:0] main_src_q;
  logic       ptr_tp_q;
  logic       ptr_ew_q;
  logic [7:0] tp_q;
  logic [7:0] ew_q;
  logic [7:0] mask_main_q;
  logic [7:0] mask_tp_q;
  logic [7:0] mask_ew_q;
  logic       irq_q;

  wire rd_main = reg_done & (addr_q == `FWIU_ADDR_MAIN);
  wire rd_tp   = reg_done & (addr_q == `FWIU_ADDR_TP);
  wire rd_ew   = reg_done & (addr_q == `FWIU_ADDR_EW);
  wire rd_st2  = reg_done & (addr_q == `FWIU_ADDR_ST2);
  wire [5:0] main_set = {wl_evt, main_evt};

  // Set beats clear so an event landing on the read is kept
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      main_src_q <= 6'h00;
      tp_q       <= 8'h00;
      ew_q       <= 8'h00;
      ptr_tp_q   <= 1'b0;
      ptr_ew_q   <= 1'b0;
    end else begin
      main_src_q <= (main_src_q & ~{6{rd_main}}) | main_set;
      tp_q       <= (tp_q & ~{8{rd_tp}}) | tp_evt;
      ew_q       <= (ew_q & ~{8{rd_ew}}) | ew_evt;
      ptr_tp_q   <= (ptr_tp_q & ~rd_tp) | (|tp_evt);
      ptr_ew_q   <= (ptr_ew_q & ~rd_ew) | (|ew_evt);
    end
  end

  // Pointer bits add nothing here: their auxiliary flags carry the request
  wire irq_d = (|(main_src_q & ~mask_main_q[7:2]))
             | (|(tp_q & ~mask_tp_q))
             | (|(ew_q & ~mask_ew_q));

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second status register

  logic       ovf_q;
  logic       udf_q;
  logic       lb_incomplete_q;
  logic [2:0] last_byte_valid_bit_count_q;
  logic       last_byte_parity_flag_q;
  wire        st2_clr = rd_st2 | fifo_clr;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ovf_q <= 1'b0;
      udf_q <= 1'b0;
    end else begin
      ovf_q <= (ovf_q & ~st2_clr) | ovf_evt;
      udf_q <= (udf_q & ~st2_clr) | host_udf | tx_udf;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lb_incomplete_q             <= 1'b0;
      last_byte_valid_bit_count_q <= 3'h0;
      last_byte_parity_flag_q     <= 1'b0;
    end else if (rx_last_set) begin
      lb_incomplete_q             <= rx_last_incomplete;
      last_byte_valid_bit_count_q <= rx_last_bits;
      last_byte_parity_flag_q     <= rx_last_parity;
    end else if (st2_clr) begin
      lb_incomplete_q             <= 1'b0;
      last_byte_valid_bit_count_q <= 3'h0;
      last_byte_parity_flag_q     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register write and readback

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_q       <= `FWIU_CFG_RST;
      mask_main_q <= `FWIU_MASK_RST;
      mask_tp_q   <= `FWIU_MASK_RST;
      mask_ew_q   <= `FWIU_MASK_RST;
    end else if (wr_reg) begin
      if (addr_q == `FWIU_ADDR_CFG) begin
        cfg_q <= byte_in;
      end
      if (addr_q == `FWIU_ADDR_MASK_MAIN) begin
        mask_main_q <= byte_in;
      end
      if (addr_q == `FWIU_ADDR_MASK_TP) begin
        mask_tp_q <= byte_in;
      end
      if (addr_q == `FWIU_ADDR_MASK_EW) begin
        mask_ew_q <= byte_in;
      end
    end
  end

  fwiu_byte_t st2_val;
  fwiu_byte_t reg_rdata;
  fwiu_byte_t out_val;
  assign st2_val = {ovf_q, udf_q, lb_incomplete_q, last_byte_valid_bit_count_q,
                    last_byte_parity_flag_q, 1'b0};
  // Unmapped addresses read as zero
  assign reg_rdata =
      (addr_q == `FWIU_ADDR_CFG)       ? cfg_q :
      (addr_q == `FWIU_ADDR_MASK_MAIN) ? mask_main_q :
      (addr_q == `FWIU_ADDR_MASK_TP)   ? mask_tp_q :
      (addr_q == `FWIU_ADDR_MASK_EW)   ? mask_ew_q :
      (addr_q == `FWIU_ADDR_MAIN)      ? {main_src_q, ptr_tp_q, ptr_ew_q} :
      (addr_q == `FWIU_ADDR_TP)        ? tp_q :
      (addr_q == `FWIU_ADDR_EW)        ? ew_q :
      (addr_q == `FWIU_ADDR_ST1)       ? {1'b0, count_q} :
      (addr_q == `FWIU_ADDR_ST2)       ? st2_val : 8'h00;
  assign out_val = in_fread ? (fifo_empty ? 8'h00 : mem_rdata) : reg_rdata;

  // Output byte is captured at the first rising SCLK of each byte,
  // long after the previous pop, so the store's read data has settled
  always_ff @(posedge ref_clk) begin
    if (reset || ss_n) begin
      sh_out_q      <= 7'h00;
      fread_empty_q <= 1'b0;
      miso_oe       <= 1'b0;
      miso          <= 1'b0;
    end else if (sclk_rise && (in_read || in_fread)) begin
      miso_oe <= 1'b1;
      if (out_load) begin
        miso          <= out_val[7];
        sh_out_q      <= out_val[6:0];
        fread_empty_q <= in_fread & fifo_empty;
      end else begin
        miso     <= sh_out_q[6];
        sh_out_q <= {sh_out_q[5:0], 1'b0};
      end
    end
  end

  assign irq = irq_q;

endmodule
`default_nettype wire

// ---- verilog/fwiu_defs.svh ----
// Purpose: Constants for the FIFO water-level and event-flag unit
// Assumes: Included by its bare name from the top module and the bench
// Notes:   Offsets are serial-port register addresses (6 bits)
`ifndef FWIU_DEFS_SVH
`define FWIU_DEFS_SVH

// Serial port modes and FIFO trailers
`define FWIU_MODE_WRITE     2'h0
`define FWIU_MODE_READ      2'h1
`define FWIU_MODE_FIFO      2'h2
`define FWIU_MODE_DIRECT    2'h3
`define FWIU_TRAILER_LOAD   6'h00
`define FWIU_TRAILER_FREAD  6'h3f

// Register addresses
`define FWIU_ADDR_CFG       6'h09
`define FWIU_ADDR_MASK_MAIN 6'h14
`define FWIU_ADDR_MASK_TP   6'h15
`define FWIU_ADDR_MASK_EW   6'h16
`define FWIU_ADDR_MAIN      6'h17
`define FWIU_ADDR_TP        6'h18
`define FWIU_ADDR_EW        6'h19
`define FWIU_ADDR_ST1       6'h1a
`define FWIU_ADDR_ST2       6'h1b

// Reset values
`define FWIU_CFG_RST        8'h00
`define FWIU_MASK_RST       8'h00

// Field positions
`define FWIU_CFG_WL_RX      0
`define FWIU_CFG_WL_TX      1
`define FWIU_ST2_OVF        7
`define FWIU_ST2_UDF        6
`define FWIU_ST2_INCOMPLETE 5
`define FWIU_ST2_BITS_LSB   2
`define FWIU_ST2_PARITY     1

// FIFO sizing and water levels
`define FWIU_FIFO_DEPTH     7'h60
`define FWIU_PTR_LAST       7'h5f
`define FWIU_WL_RX0         7'h40
`define FWIU_WL_RX1         7'h50
`define FWIU_WL_TX0         7'h20
`define FWIU_WL_TX1         7'h10
`define FWIU_TX_LOW         7'h04
`define FWIU_BUF_DEPTH      8

`endif

// ---- verilog/fwiu_pkg.sv ----
// Purpose: Types for the FIFO water-level and event-flag unit
// Assumes: Nothing
// Notes:   Constants live in fwiu_defs.svh
package fwiu_pkg;

  typedef logic [7:0] fwiu_byte_t;

  typedef enum logic [5:0] {
    SP_CMD    = 6'h01,
    SP_WRITE  = 6'h02,
    SP_READ   = 6'h04,
    SP_LOAD   = 6'h08,
    SP_FREAD  = 6'h10,
    SP_IGNORE = 6'h20
  } fwiu_spi_state_t;

endpackage

// ---- verilog/fwiu_mem.sv ----
// Purpose: 96-byte storage for the shared transmit/receive FIFO
// Assumes: One write and one read port, single clock
// Notes:   Read data is registered, one cycle behind the address
`timescale 1ns/1ns
`default_nettype none
module fwiu_mem (
  input  wire logic               ref_clk,
  input  wire logic               we,
  input  wire logic [6:0]         waddr,
  input  wire fwiu_pkg::fwiu_byte_t wdata,
  input  wire logic [6:0]         raddr,
  output var  fwiu_pkg::fwiu_byte_t rdata_q
);
  import fwiu_pkg::*;

  fwiu_byte_t mem [0:95];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end

endmodule
`default_nettype wire

// ---- verilog/fwiu_buf.sv ----
// Purpose: Small staging FIFO between the byte store and the framer
// Assumes: Power-of-two depth not required
// Notes:   Output stage is a register so the consumer sees flop outputs
`timescale 1ns/1ns
`default_nettype none
module fwiu_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output wire logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] arr [0:DEPTH-1];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;
  wire              push = in_valid & in_ready;
  wire              load = (~out_valid | out_ready) & (cnt_q != '0);

  function automatic logic [AW-1:0] wrap(input logic [AW-1:0] i);
    wrap = (i == AW'(DEPTH - 1)) ? '0 : i + 1'b1;
  endfunction

  assign in_ready = (cnt_q != CW'(DEPTH));

  always_ff @(posedge ref_clk) begin
    if (push) begin
      arr[wr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || flush) begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      if (push) begin
        wr_q <= wrap(wr_q);
      end
      if (load) begin
        rd_q     <= wrap(rd_q);
        out_data <= arr[rd_q];
      end
      if (load) begin
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      cnt_q <= cnt_q + CW'(push) - CW'(load);
    end
  end

endmodule
`default_nettype wire

// ---- test/fwiu_props.sv ----
// Purpose: Port-level properties of the FIFO and event-flag unit
// Assumes: Bound to fwiu_top, one clock domain
// Notes:   Mask state is invisible here, so irq is tied to activity
`timescale 1ns/1ns
`default_nettype none
module fwiu_props (
  input wire logic                 ref_clk,
  input wire logic                 reset,
  input wire logic                 ss_n,
  input wire logic                 sclk,
  input wire logic                 miso,
  input wire logic                 miso_oe,
  input wire logic                 irq,
  input wire logic [4:0]           main_evt,
  input wire logic [7:0]           tp_evt,
  input wire logic [7:0]           ew_evt,
  input wire logic                 rx_byte_valid,
  input wire logic                 tx_active,
  input wire logic                 tx_start,
  input wire logic                 tx_ready,
  input wire fwiu_pkg::fwiu_byte_t tx_data,
  input wire logic                 tx_valid
);
  import fwiu_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic       busy;
  logic [3:0] idle_q;
  logic [3:0] sel_q;
  assign busy = |{main_evt, tp_evt, ew_evt, rx_byte_valid, tx_active, ~ss_n};
  // Cycles since any cause of an irq change
  always_ff @(posedge ref_clk) begin
    idle_q <= (reset || busy) ? 4'h0 : idle_q + {3'h0, idle_q != 4'hf};
    sel_q  <= (reset || !ss_n) ? 4'h0 : sel_q + {3'h0, sel_q != 4'hf};
  end
  a_reset_quiet: assert property ($fell(reset) |-> !irq && !miso_oe && !tx_valid)
    else $error("outputs active after reset");
  a_irq_cause: assert property ($rose(irq) |-> idle_q < 4'h6)
    else $error("irq rose without an event");
  a_irq_fall_read: assert property ($fell(irq) |-> sel_q < 4'h6)
    else $error("irq fell without a host access");
  a_oe_release: assert property (ss_n |=> !miso_oe)
    else $error("miso driven while deselected");
  a_oe_on_rise: assert property ($rose(miso_oe) |-> !ss_n && sclk && $past(sclk))
    else $error("miso enabled off a clock rise");
  a_miso_on_rise: assert property (miso_oe && $past(miso_oe) && $changed(miso)
    |-> $past(sclk) && !$past(sclk, 2))
    else $error("miso changed off a clock rise");
  a_tx_hold: assert property (tx_valid && !tx_ready && !tx_start |=> tx_valid && $stable(tx_data))
    else $error("framer byte dropped before accept");
  a_tx_flush: assert property (tx_start |=> !tx_valid)
    else $error("framer byte after flush");
  a_tx_source: assert property ($rose(tx_valid) |-> $past(tx_active) || $past(tx_active, 2))
    else $error("framer byte without transmit");
  c_irq_rise: cover property ($rose(irq));
  c_tx_stall: cover property (tx_valid && !tx_ready);
  c_read_byte: cover property ($rose(miso_oe));
endmodule
bind fwiu_top fwiu_props u_props (
  .ref_clk(ref_clk), .reset(reset), .ss_n(ss_n), .sclk(sclk), .miso(miso),
  .miso_oe(miso_oe), .irq(irq), .main_evt(main_evt), .tp_evt(tp_evt), .ew_evt(ew_evt),
  .rx_byte_valid(rx_byte_valid), .tx_active(tx_active), .tx_start(tx_start),
  .tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid)
);
`default_nettype wire

// ---- test/fwiu_mcu.sv ----
// Purpose: Host microcontroller model on the serial port
// Assumes: Mode 1 framing, MSB first
// Notes:   Read bytes are strobed out for one cycle on rd_stb
`timescale 1ns/1ns
`default_nettype none
module fwiu_mcu (
  input  wire logic       ref_clk,
  input  wire logic       miso,
  input  wire logic       miso_oe,
  output var  logic       ss_n,
  output var  logic       sclk,
  output var  logic       mosi,
  output var  logic       rd_stb,
  output var  logic [7:0] rd_byte
);
  initial begin
    {ss_n, sclk, mosi, rd_stb, rd_byte} = {3'h4, 9'h0};
  end
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic sel;
    ss_n = 1'b0;
    tk(2);
  endtask
  // Hold select past the last fall, then release
  task automatic desel;
    tk(16);
    ss_n = 1'b1;
    mosi = ~mosi;
    tk(6);
  endtask
  // Five cycles high and six low keep the serial clock well under the core rate
  task automatic xfer(input logic [7:0] d, input logic rd);
    logic [7:0] r;
    for (int i = 7; i >= 0; i--) begin
      mosi = d[i];
      tk(5);
      sclk = 1'b1;
      tk(5);
      r[i] = miso_oe ? miso : 1'bx;
      sclk = 1'b0;
      tk(1);
    end
    if (rd) begin
      rd_byte = r;
      rd_stb = 1'b1;
      tk(1);
      rd_stb = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- test/fwiu_tb_top.sv ----
// Purpose: Self-checking bench for the FIFO water-level and event-flag unit
// Assumes: Host model drives the serial port
// Notes:   Read and framer bytes are checked against queues of notes
`timescale 1ns/1ns
`default_nettype none
`include "fwiu_defs.svh"
module fwiu_tb_top;
  import fwiu_pkg::*;
  logic       ref_clk, reset, ss_n, sclk, mosi, miso, miso_oe, irq, rd_stb;
  logic       rx_active, rx_start, rx_byte_valid, rx_last_set, rx_last_incomplete;
  logic       rx_last_parity, tx_active, tx_start, tx_frame_loaded, tx_ready, tx_valid;
  logic [2:0] rx_last_bits;
  logic [4:0] main_evt;
  logic [7:0] tp_evt, ew_evt, rd_byte;
  fwiu_byte_t rx_byte, tx_data, v;
  fwiu_byte_t eq[$], tq[$], fq[$];
  int         error_cnt, compares, seed, rs;
  int         tn[2] = '{40, 10};
  fwiu_top uut (.ref_clk(ref_clk), .reset(reset), .ss_n(ss_n), .sclk(sclk), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .irq(irq), .main_evt(main_evt), .tp_evt(tp_evt),
    .ew_evt(ew_evt), .rx_active(rx_active), .rx_start(rx_start), .rx_byte(rx_byte),
    .rx_byte_valid(rx_byte_valid), .rx_last_set(rx_last_set), .rx_last_bits(rx_last_bits),
    .rx_last_incomplete(rx_last_incomplete), .rx_last_parity(rx_last_parity),
    .tx_active(tx_active), .tx_start(tx_start), .tx_frame_loaded(tx_frame_loaded),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid));
  fwiu_mcu mcu (.ref_clk(ref_clk), .miso(miso), .miso_oe(miso_oe), .ss_n(ss_n),
    .sclk(sclk), .mosi(mosi), .rd_stb(rd_stb), .rd_byte(rd_byte));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic acc(input logic [7:0] c, input int n, input logic r, input logic [7:0] d);
    mcu.sel();
    mcu.xfer(c, 1'b0);
    repeat (n) mcu.xfer(d, r);
    mcu.desel();
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    acc({`FWIU_MODE_WRITE, a}, 1, 1'b0, d);
  endtask
  task automatic rd(input logic [5:0] a, input int n);
    acc({`FWIU_MODE_READ, a}, n, 1'b1, 8'h00);
  endtask
  task automatic irq_is(input logic e);
    tk(4);
    chk("irq", {7'h0, e}, {7'h0, irq});
  endtask
  always @(posedge ref_clk) begin
    if (rd_stb) chk("spi_rd", eq.pop_front(), rd_byte);
    if (!reset && tx_valid === 1'b1 && tx_ready) chk("tx_data", tq.pop_front(), tx_data);
  end
  always @(posedge ref_clk) begin
    #1;
    tx_ready = ($random(rs) & 3) != 0;
  end
  initial begin
    {seed, rs, reset} = {32'ha33f, 32'ha33f, 1'b1};
    {main_evt, tp_evt, ew_evt, rx_active, rx_start, rx_byte_valid, rx_byte} = '0;
    {rx_last_set, rx_last_incomplete, rx_last_bits, rx_last_parity} = '0;
    {tx_active, tx_start, tx_frame_loaded, tx_ready} = '0;
    tk(2);
    reset = 1'b0;
    v = $random(seed);
    eq = {eq, 8'h00, 8'h00, v, 8'hff, 8'h00, 8'h00};
    rd(`FWIU_ADDR_MASK_TP, 2);
    wr(`FWIU_ADDR_MASK_TP, v);
    wr(`FWIU_ADDR_MASK_EW, 8'hff);
    wr(`FWIU_ADDR_ST1, 8'h55);
    rd(`FWIU_ADDR_MASK_TP, 2);
    rd(`FWIU_ADDR_ST1, 1);
    rd(6'h3e, 1);
    wr(`FWIU_ADDR_MASK_TP, 8'h00);
    $display("Test registers done");
    v = $random(seed) | 8'h01;
    tp_evt = v;
    tk(1);
    {tp_evt, ew_evt} = {8'h00, 8'h81};
    tk(1);
    ew_evt = 8'h00;
    irq_is(1'b1);
    eq = {eq, 8'h03, 8'h03, v, 8'h81, 8'h00};
    rd(`FWIU_ADDR_MAIN, 1);
    irq_is(1'b1);
    rd(`FWIU_ADDR_MAIN, 3);
    irq_is(1'b0);
    rd(`FWIU_ADDR_MAIN, 1);
    ew_evt = 8'h10;
    tk(1);
    ew_evt = 8'h00;
    irq_is(1'b0);
    main_evt = 5'h15;
    tk(1);
    main_evt = 5'h00;
    irq_is(1'b1);
    eq = {eq, 8'h55, 8'h00, 8'h10};
    rd(`FWIU_ADDR_MAIN, 3);
    irq_is(1'b0);
    $display("Test flags done");
    wr(`FWIU_ADDR_CFG, 8'h01);
    rx_start = 1'b1;
    tk(1);
    {rx_start, rx_active} = 2'h1;
    for (int i = 1; i <= 97; i++) begin
      rx_byte = $random(seed);
      if (i <= 96) fq.push_back(rx_byte);
      rx_byte_valid = 1'b1;
      tk(1);
      rx_byte_valid = 1'b0;
      if (i == 79 || i == 80) irq_is(i == 80);
      if (i == 80) begin
        eq = {eq, 8'h50, 8'h80};
        rd(`FWIU_ADDR_ST1, 1);
        rd(`FWIU_ADDR_MAIN, 1);
      end
    end
    {rx_last_incomplete, rx_last_bits, rx_last_parity, rx_last_set} = 6'h37;
    tk(1);
    {rx_last_set, rx_active} = 2'h0;
    eq = {eq, 8'h00, 8'h60, 8'hb6, 8'h00, fq, 8'h00, 8'h40, 8'h00, 8'h00};
    rd(`FWIU_ADDR_MAIN, 1);
    rd(`FWIU_ADDR_ST1, 2);
    rd(`FWIU_ADDR_ST2, 1);
    acc({`FWIU_MODE_FIFO, `FWIU_TRAILER_FREAD}, 97, 1'b1, 8'h00);
    rd(`FWIU_ADDR_ST2, 1);
    rx_byte_valid = 1'b1;
    tk(1);
    {rx_byte_valid, rx_start} = 2'h1;
    tk(1);
    rx_start = 1'b0;
    rd(`FWIU_ADDR_ST1, 2);
    $display("Test receive done");
    foreach (tn[k]) begin
      tx_start = 1'b1;
      tk(1);
      tx_start = 1'b0;
      mcu.sel();
      mcu.xfer({`FWIU_MODE_FIFO, `FWIU_TRAILER_LOAD}, 1'b0);
      repeat (tn[k]) begin
        v = $random(seed);
        tq.push_back(v);
        mcu.xfer(v, 1'b0);
      end
      mcu.desel();
      eq = {eq, 8'(tn[k]), 8'h80, 8'h40};
      rd(`FWIU_ADDR_ST1, 1);
      tx_active = 1'b1;
      for (int i = 0; i < 5000 && tq.size() > 0; i++) tk(1);
      if (tq.size() > 0) begin
        chk("tx_drain", 8'h00, 8'(tq.size()));
        finish_test();
      end
      tk(20);
      tx_active = 1'b0;
      irq_is(1'b1);
      rd(`FWIU_ADDR_MAIN, 1);
      rd(`FWIU_ADDR_ST2, 1);
    end
    $display("Test transmit done");
    finish_test();
  end
endmodule
`default_nettype wire
